// File: logic/smu_regs.svh
// Register offsets, field positions, resets and cycle counts
// Function
// - int16 to float, stack down, 62 cycles
// - Float multiply, product replaces second, up
// - Float subtract top from second, up
// - Exponent over/underflow flagged, mantissa kept
// - Common log of top, bad input errors
// - Natural log of top, bad input errors
// - No-operation clears status, four cycles
// - Command bit 7 drives service request
// - Both 32-bit pops rotate stack up
// - 16-bit pop rotates 16-bit stack up
// - Both 32-bit duplicates copy top down
// - Push pi moves stack down, pi on top
// - 16-bit duplicate copies top, bottom lost
// - Stack commands update sign and zero
// - Power raises second to top's power
// - One store seen as 4x32 or 8x16
`ifndef SMU_REGS_SVH
`define SMU_REGS_SVH

// Byte offsets on the register bus
`define SMU_CMD_OFS 8'h00
`define SMU_PUSH16_OFS 8'h04
`define SMU_TOP_OFS 8'h08
`define SMU_STAT_OFS 8'h0c
`define SMU_IRQ_STAT_OFS 8'h10
`define SMU_IRQ_CLR_OFS 8'h14
`define SMU_IRQ_EN_OFS 8'h18
`define SMU_PUSH32_OFS 8'h1c

// Status byte fields
`define SMU_ST_BUSY 7
`define SMU_ST_SIGN 6
`define SMU_ST_ZERO 5
`define SMU_ST_ERR_LSB 1
`define SMU_ERR_NONE 4'h0
`define SMU_ERR_UNDER 4'h2
`define SMU_ERR_OVER 4'h3
`define SMU_ERR_DOMAIN 4'h4
`define SMU_SVC_BIT 7

// Interrupt status bits and reset values
`define SMU_IRQ_DONE 0
`define SMU_IRQ_ERR 1
`define SMU_IRQ_EN_RST 2'h0
`define SMU_STAT_RST 7'h00

// Command codes with the service request bit stripped
`define SMU_OP_NOP 7'h00
`define SMU_OP_FLT16 7'h1d
`define SMU_OP_MUL 7'h12
`define SMU_OP_SUB 7'h11
`define SMU_OP_LOG10 7'h08
`define SMU_OP_LN 7'h09
`define SMU_OP_PWR 7'h0b
`define SMU_OP_POP32A 7'h38
`define SMU_OP_POP32B 7'h18
`define SMU_OP_POP16 7'h78
`define SMU_OP_DUP32A 7'h37
`define SMU_OP_DUP32B 7'h17
`define SMU_OP_PI 7'h1a
`define SMU_OP_DUP16 7'h77

// Execution times in clock cycles
`define SMU_CYC_NOP 4
`define SMU_CYC_FLT16 62
`define SMU_CYC_MUL 146
`define SMU_CYC_SUB 70
`define SMU_CYC_SUB_ZERO 26
`define SMU_CYC_LOG_BAD 20
`define SMU_CYC_LOG10 4474
`define SMU_CYC_LN 4298
`define SMU_CYC_PWR 8290
`define SMU_CYC_POP32 12
`define SMU_CYC_POP16 10
`define SMU_CYC_DUP32 20
`define SMU_CYC_PI 16
`define SMU_CYC_DUP16 16

// Float constants: sign, 7-bit exponent, 24-bit mantissa
`define SMU_FLT_PI 32'h02c90fdb
`define SMU_FLT_LN2 32'h00b17218
`define SMU_FLT_LG2 32'h7f9a209b

`endif

// File: logic/smu_pkg.sv
// Types shared by the stack math unit
package smu_pkg;
    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        smu_idle = 2'b01,
        smu_run = 2'b10
    } smu_state_t;
    // Decoded command kinds
    typedef enum logic [3:0] {
        smu_op_nop, smu_op_flt16, smu_op_mul, smu_op_sub,
        smu_op_log10, smu_op_ln, smu_op_pwr, smu_op_pop32,
        smu_op_pop16, smu_op_dup32, smu_op_pi, smu_op_dup16,
        smu_op_bad
    } smu_op_t;
endpackage

// File: logic/smu_fpu.sv
// Combinational float arithmetic of the stack math unit
`timescale 1ns/1ps
`include "smu_regs.svh"
module smu_fpu (
    input wire logic [31:0] opa,
    input wire logic [31:0] opb,
    output logic [31:0] flt16_r,
    output logic [31:0] mul_r,
    output logic [3:0] mul_e,
    output logic [31:0] sub_r,
    output logic [3:0] sub_e,
    output logic [31:0] lg10_r,
    output logic [31:0] ln_r,
    output logic [31:0] pwr_r,
    output logic [3:0] pwr_e
);
    // Normalise mm/2^48 * 2^ee; returns {ovf, unf, float}
    function automatic logic [33:0] fnorm(input logic s,
        input logic signed [9:0] ee, input logic [47:0] mm);
        logic [47:0] t;
        logic signed [9:0] e;
        t = mm;
        e = ee;
        for (int i = 0; i < 48; i++) begin
            if (!t[47] && t != 48'h0) begin
                t = t << 1;
                e = e - 10'sd1;
            end
        end
        if (mm == 48'h0) return 34'h0;
        // Exponent wraps in 7 bits, i.e. offset by 128
        return {e > 10'sd63, e < -10'sd64, s, e[6:0], t[47:24]};
    endfunction

    // Sign-extended exponent
    function automatic logic signed [9:0] fexp(input logic [31:0] f);
        return {{3{f[30]}}, f[30:24]};
    endfunction

    // Product of two floats
    function automatic logic [33:0] fprod(input logic [31:0] a,
        input logic [31:0] b);
        return fnorm(a[31] ^ b[31], fexp(a) + fexp(b),
            a[23:0] * b[23:0]);
    endfunction

    // Float to log2 in signed Q16, linear mantissa fit
    function automatic logic signed [31:0] l2fix(input logic [31:0] a);
        return ({{9{a[30]}}, a[30:24], 16'h0000} +
            {15'h0000, a[23:7]}) - 32'sh00020000;
    endfunction

    // Signed Q16 to float
    function automatic logic [31:0] fix2flt(input logic signed [31:0] v);
        logic [31:0] mag;
        logic [33:0] r;
        mag = v[31] ? 32'(-v) : v;
        r = fnorm(v[31], 10'sd16, {mag, 16'h0000});
        return r[31:0];
    endfunction

    logic [15:0] mag16;
    logic [33:0] flt16_f, mul_f, sub_f, lg10_f, ln_f, y_f;
    logic [31:0] log2_flt;
    logic signed [9:0] ea, eb, emax, ey, ek;
    logic [9:0] dsh, psh;
    logic [47:0] xa, xb, ty;
    logic signed [49:0] diff;
    logic [47:0] dmag;
    logic signed [31:0] yfix;

    always_comb begin
        mag16 = opa[31] ? 16'(-opa[31:16]) : opa[31:16];
        flt16_f = fnorm(opa[31], 10'sd16, {mag16, 32'h0});
        flt16_r = flt16_f[31:0];
    end

    always_comb begin
        mul_f = fprod(opa, opb);
        mul_r = mul_f[31:0];
        mul_e = mul_f[33] ? `SMU_ERR_OVER :
            (mul_f[32] ? `SMU_ERR_UNDER : `SMU_ERR_NONE);
    end

    // Subtract top from second, aligned to larger exponent
    always_comb begin
        ea = fexp(opa);
        eb = fexp(opb);
        xa = {1'b0, opa[23:0], 23'h0};
        xb = {1'b0, opb[23:0], 23'h0};
        emax = (ea > eb) ? ea : eb;
        dsh = 10'(emax - ((ea > eb) ? eb : ea));
        if (ea > eb) xb = (dsh > 10'd47) ? 48'h0 : xb >> dsh;
        else xa = (dsh > 10'd47) ? 48'h0 : xa >> dsh;
        diff = (opb[31] ? -$signed({2'b00, xb}) : $signed({2'b00, xb}))
            - (opa[31] ? -$signed({2'b00, xa}) : $signed({2'b00, xa}));
        dmag = diff[49] ? 48'(-diff) : diff[47:0];
        sub_f = fnorm(diff[49], emax + 10'sd1, dmag);
        if (opa[23:0] == 24'h0) sub_f = {2'b00, opb};
        else if (opb[23:0] == 24'h0) sub_f = {2'b00, ~opa[31], opa[30:0]};
        sub_r = sub_f[31:0];
        sub_e = sub_f[33] ? `SMU_ERR_OVER :
            (sub_f[32] ? `SMU_ERR_UNDER : `SMU_ERR_NONE);
    end

    // Logs scale log2 by a constant
    always_comb begin
        log2_flt = fix2flt(l2fix(opa));
        lg10_f = fprod(log2_flt, `SMU_FLT_LG2);
        ln_f = fprod(log2_flt, `SMU_FLT_LN2);
        lg10_r = lg10_f[31:0];
        ln_r = ln_f[31:0];
    end

    // Power as 2^(top * log2 second), linear fraction fit
    always_comb begin
        y_f = fprod(opa, fix2flt(l2fix(opb)));
        ey = fexp(y_f[31:0]);
        // Own shift amount, the subtract block drives dsh
        psh = 10'(10'sd32 - ey);
        ty = (ey > 10'sd7 || psh > 10'd47) ? 48'h0 :
            {y_f[23:0], 24'h0} >> psh;
        yfix = y_f[31] ? -$signed(ty[31:0]) : $signed(ty[31:0]);
        ek = 10'(yfix >>> 16) + 10'sd1;
        pwr_r = {1'b0, ek[6:0], 1'b1, yfix[15:0], 7'h00};
        pwr_e = `SMU_ERR_NONE;
        if (opb[31] || opb[23:0] == 24'h0) begin
            pwr_e = `SMU_ERR_DOMAIN;
            pwr_r = opa;
        end else if (ey > 10'sd7 || ek > 10'sd63) begin
            pwr_e = `SMU_ERR_OVER;
        end else if (ek < -10'sd64) begin
            pwr_e = `SMU_ERR_UNDER;
        end
    end
endmodule

// File: logic/smu_top.sv
// Stack math unit: AHB-Lite registers, command sequencer, stack
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "smu_regs.svh"
module smu_top #(
    parameter int LOG10_CYCLES = `SMU_CYC_LOG10,
    parameter int LN_CYCLES = `SMU_CYC_LN,
    parameter int PWR_CYCLES = `SMU_CYC_PWR,
    parameter int CNT_W = 14
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    output logic srv_req_line
);
    // Counts must fit the countdown and be at least one cycle
    if (CNT_W < 8 || CNT_W > 24) begin : g_bad_width
        $error("smu_top: CNT_W out of range");
    end
    if (LOG10_CYCLES < 1 || LN_CYCLES < 1 || PWR_CYCLES < 1 ||
        LOG10_CYCLES >= 2 ** CNT_W || LN_CYCLES >= 2 ** CNT_W ||
        PWR_CYCLES >= 2 ** CNT_W) begin : g_bad_count
        $error("smu_top: cycle count does not fit counter");
    end

    // Sequencer state
    smu_pkg::smu_state_t state_q;
    smu_pkg::smu_op_t op_q;
    logic svc_sel_q; // Service request choice of running command
    logic log_bad_q; // Log operand was non-positive at issue
    logic [CNT_W-1:0] cnt_q; // Cycles left minus one
    logic done; // Last cycle of a command

    // Stack storage: index 0 is the top 16-bit entry
    logic [15:0] stk_q [8];
    logic [15:0] stk_n [8];

    // Status byte below the busy bit
    logic [6:0] stat_q;
    logic [6:0] stat_n;
    logic [3:0] err_n;

    // Interrupt registers
    logic [1:0] irq_stat_q;
    logic [1:0] irq_stat_d;
    logic [1:0] irq_en_q;
    logic [1:0] irq_ev;
    logic [1:0] irq_clr;

    // Bus address phase held for the data phase
    logic ap_wr_q;
    logic [7:0] ap_addr_q;
    logic wr_cmd, wr_push16, wr_push32;
    logic addr_take;

    // Arithmetic results
    logic [31:0] top32, sec32;
    logic [31:0] flt16_r, mul_r, sub_r, lg10_r, ln_r, pwr_r;
    logic [3:0] mul_e, sub_e, pwr_e;

    // 32-bit view: upper half above lower half
    assign top32 = {stk_q[0], stk_q[1]};
    assign sec32 = {stk_q[2], stk_q[3]};

    // Map a command code, service bit stripped, to its kind
    function automatic smu_pkg::smu_op_t op_of(input logic [6:0] c);
        unique case (c)
            `SMU_OP_NOP: return smu_pkg::smu_op_nop;
            `SMU_OP_FLT16: return smu_pkg::smu_op_flt16;
            `SMU_OP_MUL: return smu_pkg::smu_op_mul;
            `SMU_OP_SUB: return smu_pkg::smu_op_sub;
            `SMU_OP_LOG10: return smu_pkg::smu_op_log10;
            `SMU_OP_LN: return smu_pkg::smu_op_ln;
            `SMU_OP_PWR: return smu_pkg::smu_op_pwr;
            `SMU_OP_POP32A, `SMU_OP_POP32B: return smu_pkg::smu_op_pop32;
            `SMU_OP_POP16: return smu_pkg::smu_op_pop16;
            `SMU_OP_DUP32A, `SMU_OP_DUP32B: return smu_pkg::smu_op_dup32;
            `SMU_OP_PI: return smu_pkg::smu_op_pi;
            `SMU_OP_DUP16: return smu_pkg::smu_op_dup16;
            // Commands not built here run as a plain wait
            default: return smu_pkg::smu_op_bad;
        endcase
    endfunction

    // Execution time of a command, less one, for its operand
    function automatic logic [CNT_W-1:0] cyc_of(
        input smu_pkg::smu_op_t op, input logic [31:0] a);
        int n;
        logic bad;
        bad = a[31] || a[23:0] == 24'h0;
        n = `SMU_CYC_NOP;
        unique case (op)
            smu_pkg::smu_op_nop, smu_pkg::smu_op_bad: n = `SMU_CYC_NOP;
            smu_pkg::smu_op_flt16: n = `SMU_CYC_FLT16;
            smu_pkg::smu_op_mul: n = `SMU_CYC_MUL;
            // Zero subtrahend takes the short path
            smu_pkg::smu_op_sub: n = (a[23:0] == 24'h0) ?
                `SMU_CYC_SUB_ZERO : `SMU_CYC_SUB;
            smu_pkg::smu_op_log10: n = bad ? `SMU_CYC_LOG_BAD : LOG10_CYCLES;
            smu_pkg::smu_op_ln: n = bad ? `SMU_CYC_LOG_BAD : LN_CYCLES;
            smu_pkg::smu_op_pwr: n = PWR_CYCLES;
            smu_pkg::smu_op_pop32: n = `SMU_CYC_POP32;
            smu_pkg::smu_op_pop16: n = `SMU_CYC_POP16;
            smu_pkg::smu_op_dup32: n = `SMU_CYC_DUP32;
            smu_pkg::smu_op_pi: n = `SMU_CYC_PI;
            smu_pkg::smu_op_dup16: n = `SMU_CYC_DUP16;
        endcase
        return CNT_W'(n - 1);
    endfunction

    // Float datapath
    smu_fpu u_fpu (
        .opa(top32),
        .opb(sec32),
        .flt16_r(flt16_r),
        .mul_r(mul_r),
        .mul_e(mul_e),
        .sub_r(sub_r),
        .sub_e(sub_e),
        .lg10_r(lg10_r),
        .ln_r(ln_r),
        .pwr_r(pwr_r),
        .pwr_e(pwr_e)
    );

    // Bus decode: writes act in the data phase
    assign addr_take = hready && hsel && htrans[1];
    assign wr_cmd = ap_wr_q && ap_addr_q == `SMU_CMD_OFS;
    assign wr_push16 = ap_wr_q && ap_addr_q == `SMU_PUSH16_OFS;
    assign wr_push32 = ap_wr_q && ap_addr_q == `SMU_PUSH32_OFS;
    assign irq_clr = (ap_wr_q && ap_addr_q == `SMU_IRQ_CLR_OFS) ?
        hwdata[1:0] : 2'h0;
    assign done = state_q == smu_pkg::smu_run && cnt_q == '0;

    // Address phase capture; writes other than word size are dropped
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= 8'h00;
        end else if (hready) begin
            ap_wr_q <= addr_take && hwrite && hsize == 3'h2;
            ap_addr_q <= haddr[7:0];
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data registered at the address phase
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata <= 32'h0;
        end else if (addr_take && !hwrite) begin
            unique case (haddr[7:0])
                `SMU_TOP_OFS: hrdata <= top32;
                `SMU_STAT_OFS: hrdata <= {24'h0,
                    state_q == smu_pkg::smu_run, stat_q};
                `SMU_IRQ_STAT_OFS: hrdata <= {30'h0, irq_stat_q};
                `SMU_IRQ_EN_OFS: hrdata <= {30'h0, irq_en_q};
                // Unmapped and write-only offsets read zero
                default: hrdata <= 32'h0;
            endcase
        end
    end

    // Commands arriving while busy are dropped
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= smu_pkg::smu_idle;
            op_q <= smu_pkg::smu_op_nop;
            svc_sel_q <= 1'b0;
            log_bad_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                smu_pkg::smu_idle: begin
                    if (wr_cmd) begin
                        state_q <= smu_pkg::smu_run;
                        op_q <= op_of(hwdata[6:0]);
                        svc_sel_q <= hwdata[`SMU_SVC_BIT];
                        log_bad_q <= top32[31] || top32[23:0] == 24'h0;
                        cnt_q <= cyc_of(op_of(hwdata[6:0]), top32);
                    end
                end
                smu_pkg::smu_run: begin
                    // Count down the execution time
                    if (cnt_q == '0) state_q <= smu_pkg::smu_idle;
                    else cnt_q <= cnt_q - 1'b1;
                end
            endcase
        end
    end

    // Line drops on issue, follows bit 7 on completion
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            srv_req_line <= 1'b0;
        end else if (state_q == smu_pkg::smu_idle && wr_cmd) begin
            srv_req_line <= 1'b0;
        end else if (done) begin
            srv_req_line <= svc_sel_q;
        end
    end

    // Stack result of the running command
    always_comb begin
        stk_n = stk_q;
        err_n = `SMU_ERR_NONE;
        unique case (op_q)
            smu_pkg::smu_op_nop, smu_pkg::smu_op_bad: begin
                stk_n = stk_q;
            end
            // Result halves on top, rest moves down one
            smu_pkg::smu_op_flt16: begin
                stk_n[0] = flt16_r[31:16];
                stk_n[1] = flt16_r[15:0];
                for (int i = 2; i < 8; i++) stk_n[i] = stk_q[i - 1];
            end
            // Result replaces second, stack moves up
            smu_pkg::smu_op_mul, smu_pkg::smu_op_sub,
            smu_pkg::smu_op_pwr: begin
                for (int i = 2; i < 6; i++) stk_n[i] = stk_q[i + 2];
                // Spent top rotates to the bottom slot
                stk_n[6] = stk_q[0];
                stk_n[7] = stk_q[1];
                if (op_q == smu_pkg::smu_op_mul) begin
                    {stk_n[0], stk_n[1]} = mul_r;
                    err_n = mul_e;
                end else if (op_q == smu_pkg::smu_op_sub) begin
                    {stk_n[0], stk_n[1]} = sub_r;
                    err_n = sub_e;
                end else if (pwr_e == `SMU_ERR_DOMAIN) begin
                    // Bad base leaves the stack alone
                    stk_n = stk_q;
                    err_n = pwr_e;
                end else begin
                    {stk_n[0], stk_n[1]} = pwr_r;
                    err_n = pwr_e;
                end
            end
            // Log replaces top or reports domain error
            smu_pkg::smu_op_log10, smu_pkg::smu_op_ln: begin
                if (log_bad_q) begin
                    err_n = `SMU_ERR_DOMAIN;
                end else if (op_q == smu_pkg::smu_op_log10) begin
                    {stk_n[0], stk_n[1]} = lg10_r;
                end else begin
                    {stk_n[0], stk_n[1]} = ln_r;
                end
            end
            smu_pkg::smu_op_pop32: begin
                for (int i = 0; i < 8; i++) stk_n[i] = stk_q[(i + 2) % 8];
            end
            smu_pkg::smu_op_pop16: begin
                for (int i = 0; i < 8; i++) stk_n[i] = stk_q[(i + 1) % 8];
            end
            // Move down, old top copied, bottom lost
            smu_pkg::smu_op_dup32: begin
                for (int i = 2; i < 8; i++) stk_n[i] = stk_q[i - 2];
            end
            smu_pkg::smu_op_pi: begin
                stk_n[0] = 16'(`SMU_FLT_PI >> 16);
                stk_n[1] = 16'(`SMU_FLT_PI);
                for (int i = 2; i < 8; i++) stk_n[i] = stk_q[i - 2];
            end
            smu_pkg::smu_op_dup16: begin
                for (int i = 1; i < 8; i++) stk_n[i] = stk_q[i - 1];
            end
        endcase
    end

    // Status byte after the running command
    always_comb begin
        stat_n = stat_q;
        unique case (op_q)
            smu_pkg::smu_op_nop: stat_n = 7'h00;
            smu_pkg::smu_op_bad: stat_n = stat_q;
            // Sign and zero of the 16-bit top
            smu_pkg::smu_op_pop16, smu_pkg::smu_op_dup16: begin
                stat_n = 7'h00;
                stat_n[`SMU_ST_SIGN] = stk_n[0][15];
                stat_n[`SMU_ST_ZERO] = stk_n[0] == 16'h0;
            end
            // Sign and zero of the 32-bit top
            default: begin
                stat_n = 7'h00;
                stat_n[`SMU_ST_SIGN] = stk_n[0][15];
                stat_n[`SMU_ST_ZERO] = {stk_n[0], stk_n[1]} == 32'h0;
                stat_n[`SMU_ST_ERR_LSB +: 4] = err_n;
            end
        endcase
    end

    // Stack storage: host pushes when idle, results at completion
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 8; i++) stk_q[i] <= 16'h0;
        end else if (done) begin
            stk_q <= stk_n;
        end else if (state_q == smu_pkg::smu_idle && wr_push16) begin
            stk_q[0] <= hwdata[15:0];
            for (int i = 1; i < 8; i++) stk_q[i] <= stk_q[i - 1];
        end else if (state_q == smu_pkg::smu_idle && wr_push32) begin
            stk_q[0] <= hwdata[31:16];
            stk_q[1] <= hwdata[15:0];
            for (int i = 2; i < 8; i++) stk_q[i] <= stk_q[i - 2];
        end
    end

    // Status register updates only at completion
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) stat_q <= `SMU_STAT_RST;
        else if (done) stat_q <= stat_n;
    end

    // Events: completion and any error report
    always_comb begin
        irq_ev = 2'h0;
        irq_ev[`SMU_IRQ_DONE] = done;
        irq_ev[`SMU_IRQ_ERR] = done &&
            stat_n[`SMU_ST_ERR_LSB +: 4] != `SMU_ERR_NONE;
        // Set wins over a clear in the same cycle
        irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;
    end

    // Sticky status, enable and the level interrupt
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_stat_q <= 2'h0;
            irq_en_q <= `SMU_IRQ_EN_RST;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (ap_wr_q && ap_addr_q == `SMU_IRQ_EN_OFS)
                irq_en_q <= hwdata[1:0];
            // Registered so the output comes from a flop
            irq <= |(irq_stat_d & irq_en_q);
        end
    end
endmodule

// File: test/smu_top_asserts.sv
// Port-level assertions for the stack math unit
`timescale 1ns/1ps
module smu_asserts (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic irq,
    input wire logic srv_req_line
);
    // Word transfers taken at this edge
    wire logic ap = hsel && hready && htrans[1] && hsize == 3'h2;
    wire logic rd = ap && !hwrite;
    wire logic wr = ap && hwrite;
    wire logic [7:0] a = haddr[7:0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("wait state or error response");
    chk_gap_zero: assert property (rd && a == 8'h20 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_stat_pad: assert property (rd && a == 8'h0c |=>
        hrdata[31:8] == 24'h0 && !hrdata[0]) else $error("status padding set");
    chk_rdata_hold: assert property (!rd |=> $stable(hrdata))
        else $error("read data moved");
    chk_cmd_srv: assert property (wr && a == 8'h00 |-> ##2 !srv_req_line)
        else $error("service request kept on accept");
    chk_irq_mask: assert property (wr && a == 8'h18 ##1
        hwdata[1:0] == 2'h0 |=> ##1 !irq)
        else $error("masked interrupt high");
    chk_srv_late: assert property ($rose(srv_req_line) |->
        !$past(srv_req_line, 4)) else $error("command ended too soon");
    chk_rst_quiet: assert property ($fell(sys_rst) |->
        !irq && !srv_req_line && hrdata == 32'h0) else $error("reset state");
endmodule
bind smu_top smu_asserts smu_asserts_inst (.*);

// File: test/smu_host.sv
// Host model: AHB-Lite master issuing single word transfers
`timescale 1ns/1ps
module smu_host (
    input wire logic clk_sys,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Bus idle from time zero
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    // one transfer at a time, each waits its answer
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        r = hrdata;
        // Released data must not look valid
        hwdata <= ~d;
    endtask
endmodule

// File: test/stack_math_unit_commands_tb.sv
// Self-checking bench for the stack math unit commands
`timescale 1ns/1ps
`include "smu_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module stack_math_unit_commands_tb;
    logic clk_sys = 0, sys_rst = 1;
    wire logic hsel, hwrite, hreadyout, hresp, irq, srv_req_line;
    wire logic [31:0] haddr, hwdata, hrdata;
    wire logic [1:0] htrans;
    wire logic [2:0] hsize;
    int fail_count = 0, checks_done = 0, cyc = 0, seed = 5, n;
    logic [31:0] r, v, pi_w = `SMU_FLT_PI;
    logic [15:0] q[$] = '{0, 0, 0, 0, 0, 0, 0, 0};
    logic [7:0] ops[15] = '{8'h00, 8'h80, 8'h38, 8'hb8, 8'h18, 8'h98,
        8'h78, 8'hf8, 8'h37, 8'hb7, 8'h17, 8'h97, 8'h1a, 8'h77, 8'hf7};
    int tim[15] = '{4, 4, 12, 12, 12, 12, 10, 10, 20, 20, 20, 20, 16, 16, 16};
    logic [7:0] errs[8] = '{8'h09, 8'h88, 8'h8b, 8'h11, 8'h1d, 8'h92, 8'h37,
        8'h12};
    int etim[8] = '{20, 20, 8290, 26, 62, 146, 20, 146};
    smu_top smu_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq(irq), .srv_req_line(srv_req_line));
    smu_host smu_host_inst (.clk_sys(clk_sys), .hready(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    initial forever #10 clk_sys = ~clk_sys;
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 50000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic run(input logic [7:0] c, input int t);
        smu_host_inst.xfer(1'b1, `SMU_CMD_OFS, {24'h0, c}, r);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (irq !== 1'b1 && n < 9000);
        `CHK(n, t + 1)
        `CHK(srv_req_line, c[7])
        smu_host_inst.xfer(1'b1, `SMU_IRQ_CLR_OFS, 32'h3, r);
    endtask
    task automatic push();
        v = $random(seed) | 32'h00010001;
        smu_host_inst.xfer(1'b1, `SMU_PUSH32_OFS, v, r);
        q = {v[31:16], v[15:0], q[0:5]};
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int a = 0; a <= 32; a += 4) begin
            smu_host_inst.xfer(1'b0, a[7:0], 32'h0, r);
            `CHK(r, 32'h0)
        end
        smu_host_inst.xfer(1'b1, `SMU_IRQ_EN_OFS, 32'h3, r);
        repeat (4) push();
        for (int i = 0; i < 15; i++) begin
            push();
            run(ops[i], tim[i]);
            case (ops[i][6:0])
                7'h38, 7'h18: q = {q[2:7], q[0:1]};
                7'h78: q = {q[1:7], q[0]};
                7'h37, 7'h17: q = {q[0:1], q[0:5]};
                7'h77: q = {q[0], q[0:6]};
                7'h1a: q = {pi_w[31:16], pi_w[15:0], q[0:5]};
                default: ;
            endcase
            smu_host_inst.xfer(1'b0, `SMU_TOP_OFS, 32'h0, r);
            `CHK(r, {q[0], q[1]})
            smu_host_inst.xfer(1'b0, `SMU_STAT_OFS, 32'h0, r);
            v = (i < 2) ? 32'h0 : {25'h0, q[0][15], 6'h0};
            `CHK(r, v)
        end
        for (int i = 0; i < 8; i++) begin
            // Zero operands, then one large one, duplicated, for an overflow
            if (i < 7) smu_host_inst.xfer(1'b1, `SMU_PUSH32_OFS,
                (i == 6) ? 32'h3f800000 : 32'h0, r);
            run(errs[i], etim[i]);
            smu_host_inst.xfer(1'b0, `SMU_STAT_OFS, 32'h0, r);
            v = (i < 3) ? 32'h4 : ((i == 7) ? 32'h3 : 32'h0);
            `CHK(r[4:1], v[3:0])
        end
        // Mantissa kept, exponent wrapped by 128
        smu_host_inst.xfer(1'b0, `SMU_TOP_OFS, 32'h0, r);
        `CHK(r, 32'h7d800000)
        smu_host_inst.xfer(1'b1, `SMU_IRQ_EN_OFS, 32'h0, r);
        smu_host_inst.xfer(1'b1, `SMU_CMD_OFS, 32'h80, r);
        repeat (8) @(posedge clk_sys);
        `CHK(irq, 1'b0)
        smu_host_inst.xfer(1'b0, `SMU_IRQ_STAT_OFS, 32'h0, r);
        `CHK(r, 32'h1)
        summarize();
    end
endmodule
